// ===== wit_top.sv
// Purpose: watch interval timer with buzzer output and avalon registers
// Assumes: main and sub clocks arrive as pins sampled by CLK_IN
// Notes: answer to every bus access comes one cycle after the request
`timescale 1ns/100ps
`default_nettype none
module wit_top (
	input  wire logic        CLK_IN,
	input  wire logic        RST_IN,
	input  wire logic        MAIN_CLK_IN,
	input  wire logic        SUB_CLK_IN,
	input  wire logic [4:0]  AVS_ADDRESS_IN,
	input  wire logic        AVS_READ_IN,
	input  wire logic        AVS_WRITE_IN,
	input  wire logic [31:0] AVS_WRITEDATA_IN,
	input  wire logic [3:0]  AVS_BYTEENABLE_IN,
	output logic      [31:0] AVS_READDATA_OUT,
	output logic             AVS_WAITREQUEST_OUT,
	output logic             IRQ_OUT,
	output logic             WAKE_OUT,
	output logic             BUZZER_OUT,
	output logic             BUZZER_OE_N_OUT
);
	logic [1:0]                     pin_s;
	logic                           main_d_r;
	logic                           sub_d_r;
	logic                           main_rise;
	logic                           sub_edge;
	logic [wit_pkg::PRE_W-1:0]      pre_r;
	logic                           pre_wrap;
	logic                           src_tick;
	logic [wit_pkg::DIV_W-1:0]      div_r;
	logic                           ivl_event;
	logic [wit_pkg::CTRL_W-1:0]     ctrl_r;
	logic [wit_pkg::STAT_W-1:0]     status_r;
	logic [wit_pkg::STAT_W-1:0]     status_nxt;
	logic [wit_pkg::STAT_W-1:0]     mask_r;
	logic                           ack_r;
	logic                           acc_done;
	logic                           clr_cmd;
	logic                           buz_tap;
	logic                           buzzer_r;
	logic                           buz_oe_n_r;
	logic [wit_pkg::DIV_W-1:0]      gap_r;
	logic                           gap_ok_r;

	function automatic logic wr_hit(input logic [4:0] ofs);
		wr_hit = AVS_WRITE_IN && !AVS_WAITREQUEST_OUT &&
			AVS_BYTEENABLE_IN[0] && (AVS_ADDRESS_IN == ofs);
	endfunction

	wit_sync u_sync (
		.clk_in (CLK_IN),
		.rst_in (RST_IN),
		.d_in   ({SUB_CLK_IN, MAIN_CLK_IN}),
		.q_out  (pin_s)
	);

	// edge detection on synchronised clock pins
	always_ff @(posedge CLK_IN) begin
		if (RST_IN) begin
			main_d_r <= 1'b0;
			sub_d_r  <= 1'b0;
		end else begin
			main_d_r <= pin_s[0];
			sub_d_r  <= pin_s[1];
		end
	end

	assign main_rise = pin_s[0] & ~main_d_r;
	assign sub_edge  = pin_s[1] ^ sub_d_r;

	// main clock prescaler down to twice the watch rate
	always_ff @(posedge CLK_IN) begin
		if (RST_IN || clr_cmd) begin
			pre_r <= '0;
		end else if (main_rise) begin
			pre_r <= pre_r + 1'b1;
		end
	end

	assign pre_wrap = main_rise && (pre_r == wit_pkg::PRE_MAX);
	assign src_tick = ctrl_r[wit_pkg::CTRL_SRC_BIT] ? sub_edge : pre_wrap;

	// watch divider
	always_ff @(posedge CLK_IN) begin
		if (RST_IN) begin
			div_r <= wit_pkg::DIV_RST;
		end else if (clr_cmd) begin
			div_r <= wit_pkg::DIV_RST;
		end else if (src_tick) begin
			div_r <= div_r + 1'b1;
		end
	end

	assign ivl_event = src_tick && !clr_cmd &&
		(ctrl_r[wit_pkg::CTRL_FAST_BIT] ?
		(&div_r[wit_pkg::FAST_W-1:0]) : (&div_r));

	// bus handshake: one wait cycle per access
	always_ff @(posedge CLK_IN) begin
		if (RST_IN) begin
			ack_r <= 1'b0;
		end else begin
			ack_r <= (AVS_READ_IN || AVS_WRITE_IN) && !ack_r;
		end
	end

	assign AVS_WAITREQUEST_OUT = (AVS_READ_IN || AVS_WRITE_IN) && !ack_r;
	assign acc_done = ack_r && (AVS_READ_IN || AVS_WRITE_IN);
	assign clr_cmd = wr_hit(wit_pkg::CMD_OFS) &&
		AVS_WRITEDATA_IN[wit_pkg::CMD_CLR_BIT];

	// control register
	always_ff @(posedge CLK_IN) begin
		if (RST_IN) begin
			ctrl_r <= wit_pkg::CTRL_RST;
		end else if (wr_hit(wit_pkg::CTRL_OFS)) begin
			ctrl_r <= AVS_WRITEDATA_IN[wit_pkg::CTRL_W-1:0];
		end
	end

	// sticky status, write one to clear, set wins
	always_comb begin
		status_nxt = status_r;
		if (wr_hit(wit_pkg::STATUS_OFS)) begin
			status_nxt = status_r & ~AVS_WRITEDATA_IN[wit_pkg::STAT_W-1:0];
		end
		if (ivl_event) begin
			status_nxt[wit_pkg::STAT_IVL_BIT] = 1'b1;
		end
	end

	always_ff @(posedge CLK_IN) begin
		if (RST_IN) begin
			status_r <= wit_pkg::STAT_RST;
		end else begin
			status_r <= status_nxt;
		end
	end

	always_ff @(posedge CLK_IN) begin
		if (RST_IN) begin
			mask_r <= wit_pkg::STAT_RST;
		end else if (wr_hit(wit_pkg::MASK_OFS)) begin
			mask_r <= AVS_WRITEDATA_IN[wit_pkg::STAT_W-1:0];
		end
	end

	assign IRQ_OUT  = |(status_r & mask_r);
	assign WAKE_OUT = status_r[wit_pkg::STAT_IVL_BIT] &&
		ctrl_r[wit_pkg::CTRL_WAKE_BIT];

	// read data captured in the wait cycle
	always_ff @(posedge CLK_IN) begin
		if (RST_IN) begin
			AVS_READDATA_OUT <= 32'h0;
		end else if (AVS_READ_IN && !ack_r) begin
			case (AVS_ADDRESS_IN)
				wit_pkg::CTRL_OFS: begin
					AVS_READDATA_OUT <= {26'h0, ctrl_r};
				end
				wit_pkg::STATUS_OFS: begin
					AVS_READDATA_OUT <= {31'h0, status_r};
				end
				wit_pkg::MASK_OFS: begin
					AVS_READDATA_OUT <= {31'h0, mask_r};
				end
				wit_pkg::COUNT_OFS: begin
					AVS_READDATA_OUT <= {17'h0, div_r};
				end
				default: begin
					AVS_READDATA_OUT <= 32'h0;
				end
			endcase
		end
	end

	// buzzer tap selection
	always_comb begin
		case (ctrl_r[wit_pkg::CTRL_SEL_LSB +: 2])
			wit_pkg::BUZ_2K048: begin
				buz_tap = div_r[wit_pkg::TAP_2K048];
			end
			wit_pkg::BUZ_4K096: begin
				buz_tap = div_r[wit_pkg::TAP_4K096];
			end
			wit_pkg::BUZ_32K768: begin
				buz_tap = div_r[wit_pkg::TAP_32K768];
			end
			default: begin
				buz_tap = 1'b0;
			end
		endcase
	end

	always_ff @(posedge CLK_IN) begin
		if (RST_IN) begin
			buzzer_r   <= 1'b0;
			buz_oe_n_r <= 1'b1;
		end else begin
			buzzer_r   <= ctrl_r[wit_pkg::CTRL_BUZ_BIT] & buz_tap;
			buz_oe_n_r <= ~ctrl_r[wit_pkg::CTRL_BUZ_BIT];
		end
	end

	assign BUZZER_OUT      = buzzer_r;
	assign BUZZER_OE_N_OUT = buz_oe_n_r;

	// checker helper: ticks between flag events, valid after clear or event
	always_ff @(posedge CLK_IN) begin
		if (RST_IN || clr_cmd || ivl_event) begin
			gap_r <= '0;
		end else if (src_tick) begin
			gap_r <= gap_r + 1'b1;
		end
	end

	always_ff @(posedge CLK_IN) begin
		if (RST_IN || wr_hit(wit_pkg::CTRL_OFS)) begin
			gap_ok_r <= 1'b0;
		end else if (clr_cmd || ivl_event) begin
			gap_ok_r <= 1'b1;
		end
	end

	// checks
	flag_set_a: assert property (@(posedge CLK_IN) disable iff (RST_IN)
		ivl_event |=> status_r[wit_pkg::STAT_IVL_BIT])
		else $error("interval flag not set after tick");

	flag_hold_a: assert property (@(posedge CLK_IN) disable iff (RST_IN)
		status_r[0] && !wr_hit(wit_pkg::STATUS_OFS) |=> status_r[0])
		else $error("interval flag dropped without clear");

	wake_out_a: assert property (@(posedge CLK_IN) disable iff (RST_IN)
		ivl_event && ctrl_r[wit_pkg::CTRL_WAKE_BIT] &&
		!wr_hit(wit_pkg::CTRL_OFS) |=> WAKE_OUT)
		else $error("wake not raised by interval flag");

	src_select_a: assert property (@(posedge CLK_IN) disable iff (RST_IN)
		$changed(div_r) && !$past(clr_cmd) |->
		$past(ctrl_r[0] ? sub_edge : pre_wrap))
		else $error("divider stepped without selected source");

	fast_feed_a: assert property (@(posedge CLK_IN) disable iff (RST_IN)
		src_tick && !clr_cmd && ctrl_r[wit_pkg::CTRL_FAST_BIT] &&
		(&div_r[wit_pkg::FAST_W-1:0]) |=> status_r[wit_pkg::STAT_IVL_BIT])
		else $error("fast interval did not set flag");

	ivl_gap_a: assert property (@(posedge CLK_IN) disable iff (RST_IN)
		ivl_event && gap_ok_r && !ctrl_r[wit_pkg::CTRL_FAST_BIT] |->
		gap_r == {wit_pkg::DIV_W{1'b1}})
		else $error("normal interval not 32768 ticks");

	fast_gap_a: assert property (@(posedge CLK_IN) disable iff (RST_IN)
		ivl_event && gap_ok_r && ctrl_r[wit_pkg::CTRL_FAST_BIT] |->
		gap_r == {{(wit_pkg::DIV_W-wit_pkg::FAST_W){1'b0}},
		{wit_pkg::FAST_W{1'b1}}})
		else $error("fast interval not 256 ticks");

	buz_follow_a: assert property (@(posedge CLK_IN) disable iff (RST_IN)
		ctrl_r[wit_pkg::CTRL_BUZ_BIT] ##1 ctrl_r[wit_pkg::CTRL_BUZ_BIT]
		|-> BUZZER_OUT == $past(buz_tap) && !BUZZER_OE_N_OUT)
		else $error("buzzer output not following tap");

	div_clear_a: assert property (@(posedge CLK_IN) disable iff (RST_IN)
		clr_cmd |=> div_r == wit_pkg::DIV_RST && pre_r == '0)
		else $error("divider not cleared");

	ctrl_reset_a: assert property (@(posedge CLK_IN)
		RST_IN |=> ctrl_r == wit_pkg::CTRL_RST && !BUZZER_OUT)
		else $error("control not zero after reset");

	bus_wait_a: assert property (@(posedge CLK_IN) disable iff (RST_IN)
		(AVS_READ_IN || AVS_WRITE_IN) && AVS_WAITREQUEST_OUT |=>
		!(AVS_READ_IN || AVS_WRITE_IN) || (acc_done && !AVS_WAITREQUEST_OUT))
		else $error("bus access not answered after one wait");

	read_back_a: assert property (@(posedge CLK_IN) disable iff (RST_IN)
		acc_done && AVS_READ_IN && AVS_ADDRESS_IN == wit_pkg::CTRL_OFS |->
		AVS_READDATA_OUT == {26'h0, $past(ctrl_r)})
		else $error("control read back wrong");

	ivl_seen_c: cover property (@(posedge CLK_IN) disable iff (RST_IN)
		ivl_event ##1 IRQ_OUT);
	fast_seen_c: cover property (@(posedge CLK_IN) disable iff (RST_IN)
		ivl_event && ctrl_r[wit_pkg::CTRL_FAST_BIT]);
	clear_seen_c: cover property (@(posedge CLK_IN) disable iff (RST_IN)
		status_r[0] && wr_hit(wit_pkg::STATUS_OFS) && ivl_event);
	clr_tick_c: cover property (@(posedge CLK_IN) disable iff (RST_IN)
		clr_cmd && src_tick);
	buz_tone_c: cover property (@(posedge CLK_IN) disable iff (RST_IN)
		!BUZZER_OE_N_OUT && BUZZER_OUT);
endmodule // wit_top
`default_nettype wire

// ===== wit_sync.sv
// Purpose: shared constants and the pin input synchroniser
// Assumes: one clock, synchronous active-high reset
// Notes: package first, then the two-flop synchroniser
package wit_pkg;
	// avalon byte offsets
	localparam logic [4:0] CTRL_OFS   = 5'h00;
	localparam logic [4:0] CMD_OFS    = 5'h04;
	localparam logic [4:0] STATUS_OFS = 5'h08;
	localparam logic [4:0] MASK_OFS   = 5'h0c;
	localparam logic [4:0] COUNT_OFS  = 5'h10;
	// control field positions
	localparam int CTRL_SRC_BIT  = 0;
	localparam int CTRL_FAST_BIT = 1;
	localparam int CTRL_BUZ_BIT  = 2;
	localparam int CTRL_SEL_LSB  = 3;
	localparam int CTRL_WAKE_BIT = 5;
	localparam int CTRL_W        = 6;
	localparam logic [CTRL_W-1:0] CTRL_RST = 6'h00;
	localparam int CMD_CLR_BIT   = 0;
	localparam int STAT_IVL_BIT  = 0;
	localparam int STAT_W        = 1;
	localparam logic [STAT_W-1:0] STAT_RST = 1'h0;
	// divider chain: input ticks at twice the watch rate
	localparam real MAIN_FREQ_MHZ = 4.19;
	localparam real SUB_FREQ_KHZ  = 32.768;
	localparam real INTERVAL_S    = 0.5;
	localparam real FAST_MS       = 3.91;
	localparam int  FAST_FACTOR   = 128;
	localparam int  PRE_W         = 6;
	localparam logic [PRE_W-1:0] PRE_MAX = 6'h3f;
	localparam int  DIV_W         = 15;
	localparam int  FAST_W        = 8;
	localparam logic [DIV_W-1:0] DIV_RST = 15'h0000;
	// buzzer frequency select codes and tap positions
	localparam logic [1:0] BUZ_2K048  = 2'h0;
	localparam logic [1:0] BUZ_4K096  = 2'h1;
	localparam logic [1:0] BUZ_32K768 = 2'h2;
	localparam int TAP_2K048  = 4;
	localparam int TAP_4K096  = 3;
	localparam int TAP_32K768 = 0;
endpackage

`timescale 1ns/100ps
`default_nettype none
module wit_sync (
	input  wire logic       clk_in,
	input  wire logic       rst_in,
	input  wire logic [1:0] d_in,
	output logic      [1:0] q_out
);
	logic [1:0] meta_r;

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			meta_r <= 2'h0;
			q_out  <= 2'h0;
		end else begin
			meta_r <= d_in;
			q_out  <= meta_r;
		end
	end
endmodule // wit_sync
`default_nettype wire

// ===== wit_buzzer_model.sv
// Purpose: buzzer-side listener counting square wave rising edges
// Assumes: pin sampled on the system clock
// Notes: counts only while the pin is driven
`timescale 1ns/100ps
`default_nettype none
module wit_buzzer_model (
	input  wire logic clk_in,
	input  wire logic buzzer_in,
	input  wire logic oe_n_in,
	output var int    rises_out
);
	logic prev_r = 1'b0;
	initial rises_out = 0;
	always @(posedge clk_in) begin
		if (!oe_n_in && buzzer_in && !prev_r) rises_out <= rises_out + 1;
		prev_r <= buzzer_in;
	end
endmodule // wit_buzzer_model
`default_nettype wire

// ===== tb_watch_interval_timer.sv
// Purpose: self-checking bench for the watch interval timer
// Assumes: pin clocks toggled slowly against CLK_IN
// Notes: expectations from divider counts and tap positions
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin mismatches++; \
	$display("[FAIL] %0t got %h exp %h", $time, a, b); end end
module tb_watch_interval_timer;
	logic        clk, rst, mclk, sclk, rd, wr, irq, wake, buzzer_output, oe_n, wreq;
	logic [4:0]  adr;
	logic [31:0] wd, rdat, q;
	logic [3:0]  be;
	int          mismatches = 0;
	int          n_tests = 0;
	int          rises;
	wit_top dut (.CLK_IN(clk), .RST_IN(rst), .MAIN_CLK_IN(mclk),
		.SUB_CLK_IN(sclk), .AVS_ADDRESS_IN(adr), .AVS_READ_IN(rd),
		.AVS_WRITE_IN(wr), .AVS_WRITEDATA_IN(wd), .AVS_BYTEENABLE_IN(be),
		.AVS_READDATA_OUT(rdat), .AVS_WAITREQUEST_OUT(wreq), .IRQ_OUT(irq),
		.WAKE_OUT(wake), .BUZZER_OUT(buzzer_output), .BUZZER_OE_N_OUT(oe_n));
	wit_buzzer_model pm (.clk_in(clk), .buzzer_in(buzzer_output), .oe_n_in(oe_n),
		.rises_out(rises));
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	task automatic bus(input logic w, input logic [4:0] a,
		input logic [31:0] d, input logic [3:0] b);
		int k;
		@(posedge clk);
		adr <= a;
		wd <= d;
		be <= b;
		rd <= ~w;
		wr <= w;
		k = 0;
		@(posedge clk);
		while (wreq !== 1'b0 && k < 50) begin
			@(posedge clk);
			k++;
		end
		if (k == 50) mismatches++;
		q = rdat;
		rd <= 1'b0;
		wr <= 1'b0;
	endtask
	task automatic wrr(input logic [4:0] a, input logic [31:0] d);
		bus(1'b1, a, d, 4'hf);
	endtask
	task automatic chk_rd(input logic [4:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0, 4'hf);
		`CHK(q, e)
	endtask
	task automatic tog(input int n, input logic m);
		repeat (n) begin
			repeat (4) @(posedge clk);
			if (m) mclk <= ~mclk;
			else sclk <= ~sclk;
		end
		repeat (6) @(posedge clk);
		#1;
	endtask
	task automatic summarize();
		$display("tests %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	task automatic t_reset();
		#1;
		`CHK(oe_n, 1'b1)
		chk_rd(wit_pkg::CTRL_OFS, 32'h0);
		chk_rd(wit_pkg::STATUS_OFS, 32'h0);
		chk_rd(5'h14, 32'h0);
		wrr(wit_pkg::CTRL_OFS, 32'h3f);
		bus(1'b1, wit_pkg::CTRL_OFS, 32'h0, 4'h0);
		chk_rd(wit_pkg::CTRL_OFS, 32'h3f);
		wrr(wit_pkg::CTRL_OFS, 32'h0);
	endtask
	task automatic t_src();
		wrr(wit_pkg::CTRL_OFS, 32'h1);
		wrr(wit_pkg::CMD_OFS, 32'h1);
		tog(100, 1'b0);
		chk_rd(wit_pkg::COUNT_OFS, 32'h64);
		wrr(wit_pkg::CMD_OFS, 32'h1);
		chk_rd(wit_pkg::COUNT_OFS, 32'h0);
		wrr(wit_pkg::CTRL_OFS, 32'h0);
		wrr(wit_pkg::CMD_OFS, 32'h1);
		tog(1280, 1'b1);
		chk_rd(wit_pkg::COUNT_OFS, 32'ha);
	endtask
	task automatic t_fast();
		wrr(wit_pkg::MASK_OFS, 32'h1);
		wrr(wit_pkg::CTRL_OFS, 32'h23);
		wrr(wit_pkg::CMD_OFS, 32'h1);
		wrr(wit_pkg::STATUS_OFS, 32'h1);
		tog(200, 1'b0);
		wrr(wit_pkg::CMD_OFS, 32'h1);
		tog(200, 1'b0);
		chk_rd(wit_pkg::STATUS_OFS, 32'h0);
		`CHK(irq, 1'b0)
		tog(60, 1'b0);
		chk_rd(wit_pkg::STATUS_OFS, 32'h1);
		`CHK(irq, 1'b1)
		`CHK(wake, 1'b1)
		wrr(wit_pkg::MASK_OFS, 32'h0);
		#1;
		`CHK(irq, 1'b0)
		chk_rd(wit_pkg::STATUS_OFS, 32'h1);
		wrr(wit_pkg::STATUS_OFS, 32'h1);
		#1;
		`CHK(wake, 1'b0)
		wrr(wit_pkg::CTRL_OFS, 32'h21);
		wrr(wit_pkg::CMD_OFS, 32'h1);
		tog(300, 1'b0);
		chk_rd(wit_pkg::STATUS_OFS, 32'h0);
	endtask
	task automatic t_buz();
		logic [1:0] sel [4];
		int         exp_r [4];
		int         c;
		sel = '{wit_pkg::BUZ_2K048, wit_pkg::BUZ_4K096,
			wit_pkg::BUZ_32K768, 2'h3};
		exp_r = '{2, 4, 32, 0};
		for (int i = 0; i < 4; i++) begin
			wrr(wit_pkg::CMD_OFS, 32'h1);
			wrr(wit_pkg::CTRL_OFS, {27'h0, sel[i], 3'h5});
			c = rises;
			tog(64, 1'b0);
			`CHK(rises - c, exp_r[i])
			`CHK(oe_n, 1'b0)
		end
		wrr(wit_pkg::CTRL_OFS, 32'h0);
		repeat (3) @(posedge clk);
		#1;
		`CHK(oe_n, 1'b1)
		`CHK(buzzer_output, 1'b0)
	endtask
	initial begin
		rst = 1'b1;
		{mclk, sclk, rd, wr} = 4'h0;
		adr = 5'h0;
		wd = 32'h0;
		be = 4'h0;
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		t_reset();
		t_src();
		t_fast();
		t_buz();
		summarize();
	end
	initial begin
		#200000;
		mismatches++;
		summarize();
	end
endmodule // tb_watch_interval_timer
`default_nettype wire
